// file: ack_mgr_pkg.sv
// constants, field layout and carrier types for the acknowledge manager
package ack_mgr_pkg;
  // register indices on the plain register port
  localparam logic [2:0] CTRL_ADDR = 3'h0;
  localparam logic [2:0] COUNT_ADDR = 3'h1;
  localparam logic [2:0] STATUS_ADDR = 3'h2;
  localparam logic [2:0] IRQ_STAT_ADDR = 3'h3;
  localparam logic [2:0] IRQ_EN_ADDR = 3'h4;
  localparam logic [2:0] IRQ_CLR_ADDR = 3'h5;
  // control_reg field positions
  localparam int ACK_EN_BIT = 0;
  localparam int GC_EN_BIT = 1;
  localparam int LB_NACK_BIT = 2;
  localparam int MODE_BIT = 3;
  localparam int GO_BIT = 4;
  // buffered mode limits of byte_count_reg
  localparam logic [6:0] COUNT_MAX = 7'h44;
  localparam logic [6:0] COUNT_RESET = 7'h00;
  // status codes
  localparam logic [7:0] STATUS_RESET = 8'hF8;
  localparam logic [7:0] STATUS_BAD_COUNT = 8'hFC;
  localparam logic [7:0] STATUS_STARTED = 8'h08;
  // interrupt event bits
  localparam int EV_BAD_COUNT = 0;
  localparam int EV_NACK = 1;
  localparam int EV_STOP = 2;
  localparam int EV_W = 3;
  // kinds of acknowledge slot offered by the framing logic
  typedef enum logic [1:0] {
    SLOT_OWN_ADDR = 2'h0,
    SLOT_GC_ADDR = 2'h1,
    SLOT_DATA = 2'h2
  } slot_kind_t;
  // one acknowledge slot from the bit-level engine
  typedef struct packed {
    logic valid;
    slot_kind_t kind;
    logic master;
  } slot_t;
  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

// file: ack_manager.sv
// acknowledge decision logic with register port and interrupt
//
// Function
// - byte mode per byte, buffered per count
// - own and general call addresses separately enabled
// - byte master receiver, ack disabled: NACK
// - byte master receiver, ack enabled: ACK
// - master transmit bytes need no decision here
// - buffered master receive, no last nack: ACK all
// - buffered master receive, last nack: NACK final byte
// - byte mode, ack disabled: NACK, drop address
// - byte mode, ack enabled: ACK, stay addressed
// - buffered own address follows ack enable
// - buffered slave ACKs up to count
// - buffered slave NACKs last with last nack set, unless stopped
// - byte general call: data follows ack enable
// - buffered general call: address follows general call enable, data by count
// - buffered bad count: no transfer, irq, FCh status
`timescale 1ns/1ps
module ack_manager (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire ack_mgr_pkg::reg_req_t req_i,
  input wire ack_mgr_pkg::slot_t slot_i,
  input wire logic stop_i,
  output logic [7:0] rdata_o,
  output logic ack_valid_o,
  output logic ack_o,
  output logic addressed_o,
  output logic xfer_start_o,
  output logic irq_o
);
  // addressing session
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_OWN = 4'b0010,
    S_GC = 4'b0100,
    S_MASTER = 4'b1000
  } sess_t;

  // buffered decision: ack unless past the count with limit set, or last byte with nack
  function automatic logic buf_ack(input logic [6:0] done, input logic [6:0] cnt,
                                   input logic lbn, input logic limit);
    logic last;
    last = ((done + 7'h01) == cnt);
    if (limit && (done >= cnt))
      buf_ack = 1'b0;
    else
      buf_ack = !(lbn && last);
  endfunction

  // event width, copied so the slices below stay short
  localparam int EV_W_L = ack_mgr_pkg::EV_W;
  logic ack_en; // software ack enable
  logic gc_en; // general call enable
  logic lb_nack; // nack the last buffered byte
  logic mode_buf; // 1 buffered, 0 byte
  logic [6:0] byte_count; // programmed transfer length
  logic [7:0] status_code; // last status code
  logic [EV_W_L-1:0] irq_stat; // sticky events
  logic [EV_W_L-1:0] irq_en; // event mask
  logic [EV_W_L-1:0] ev; // events this cycle
  sess_t sess; // current session
  logic [6:0] done; // data slots seen since the last address slot or stop, acked or not
  logic next_ack; // decision for this slot
  logic count_bad; // requested count out of range
  logic ctrl_wr; // control write this cycle

  assign ctrl_wr = req_i.wr && (req_i.addr == ack_mgr_pkg::CTRL_ADDR);
  assign count_bad = (byte_count == 7'h00) || (byte_count > ack_mgr_pkg::COUNT_MAX);

  // control settings written by software
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      ack_en <= 1'b0;
      gc_en <= 1'b0;
      lb_nack <= 1'b0;
      mode_buf <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      ack_en <= req_i.wdata[ack_mgr_pkg::ACK_EN_BIT];
      gc_en <= req_i.wdata[ack_mgr_pkg::GC_EN_BIT];
      lb_nack <= req_i.wdata[ack_mgr_pkg::LB_NACK_BIT];
      mode_buf <= req_i.wdata[ack_mgr_pkg::MODE_BIT];
    end
  end

  // programmed byte count, low seven bits kept as written so the check sees the raw value
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      byte_count <= ack_mgr_pkg::COUNT_RESET;
    else if (req_i.wr && (req_i.addr == ack_mgr_pkg::COUNT_ADDR))
      byte_count <= req_i.wdata[6:0];
  end

  // transfer request: go bit checks the count before anything moves
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      status_code <= ack_mgr_pkg::STATUS_RESET;
      xfer_start_o <= 1'b0;
    end
    else if (ctrl_wr && req_i.wdata[ack_mgr_pkg::GO_BIT])
    begin
      // bad count only matters in buffered mode
      if (req_i.wdata[ack_mgr_pkg::MODE_BIT] && count_bad)
      begin
        status_code <= ack_mgr_pkg::STATUS_BAD_COUNT;
        xfer_start_o <= 1'b0;
      end
      else
      begin
        status_code <= ack_mgr_pkg::STATUS_STARTED;
        xfer_start_o <= 1'b1;
      end
    end
    else
      xfer_start_o <= 1'b0;
  end

  // decision for the current slot, from settings as they stand now
  always_comb
  begin
    next_ack = 1'b0;
    unique case (slot_i.kind)
      ack_mgr_pkg::SLOT_OWN_ADDR:
        next_ack = ack_en;
      ack_mgr_pkg::SLOT_GC_ADDR:
        next_ack = gc_en;
      ack_mgr_pkg::SLOT_DATA:
      begin
        if (slot_i.master)
        begin
          // master receiver
          if (mode_buf)
            next_ack = buf_ack(done, byte_count, lb_nack, 1'b0);
          else
            next_ack = ack_en;
        end
        else if (sess == S_OWN || sess == S_GC)
        begin
          // addressed slave receiver or general call data
          if (mode_buf)
            next_ack = buf_ack(done, byte_count, lb_nack, 1'b1);
          else
            next_ack = ack_en;
        end
        else
          next_ack = 1'b0; // not addressed, e.g. after a refused call
      end
      default:
        next_ack = 1'b0; // illegal slot code refused
    endcase
  end

  // acknowledge outputs, registered at the slot
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      ack_valid_o <= 1'b0;
      ack_o <= 1'b0;
    end
    else
    begin
      ack_valid_o <= slot_i.valid;
      ack_o <= slot_i.valid && next_ack;
    end
  end

  // session tracking and byte counter
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      sess <= S_IDLE;
      done <= 7'h00;
    end
    else if (stop_i)
    begin
      sess <= S_IDLE;
      done <= 7'h00;
    end
    else if (slot_i.valid)
    begin
      unique case (slot_i.kind)
        ack_mgr_pkg::SLOT_OWN_ADDR:
        begin
          sess <= ack_en ? S_OWN : S_IDLE;
          done <= 7'h00;
        end
        ack_mgr_pkg::SLOT_GC_ADDR:
        begin
          sess <= gc_en ? S_GC : S_IDLE;
          done <= 7'h00;
        end
        ack_mgr_pkg::SLOT_DATA:
        begin
          if (slot_i.master)
            sess <= S_MASTER;
          // byte mode slave drops out after a refused byte
          else if (!mode_buf && !ack_en)
            sess <= S_IDLE;
          // buffered slave leaves after the last counted byte
          else if (mode_buf && sess != S_IDLE && (done + 7'h01) >= byte_count)
            sess <= S_IDLE;
          done <= done + 7'h01;
        end
        default:
          sess <= sess;
      endcase
    end
  end

  // events raised this cycle
  always_comb
  begin
    ev = '0;
    ev[ack_mgr_pkg::EV_BAD_COUNT] = ctrl_wr && req_i.wdata[ack_mgr_pkg::GO_BIT]
      && req_i.wdata[ack_mgr_pkg::MODE_BIT] && count_bad;
    ev[ack_mgr_pkg::EV_NACK] = slot_i.valid && !next_ack;
    ev[ack_mgr_pkg::EV_STOP] = stop_i;
  end

  // sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      irq_stat <= '0;
    else if (req_i.wr && (req_i.addr == ack_mgr_pkg::IRQ_CLR_ADDR))
      irq_stat <= (irq_stat & ~req_i.wdata[EV_W_L-1:0]) | ev;
    else
      irq_stat <= irq_stat | ev;
  end

  // interrupt enable mask
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      irq_en <= '0;
    else if (req_i.wr && (req_i.addr == ack_mgr_pkg::IRQ_EN_ADDR))
      irq_en <= req_i.wdata[EV_W_L-1:0];
  end

  // level interrupt, one cycle behind the sticky bits
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(irq_stat & irq_en);
  end

  // addressed flag for the framing logic
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      addressed_o <= 1'b0;
    else
      addressed_o <= (sess == S_OWN) || (sess == S_GC);
  end

  // read data, one cycle after the strobe, zero elsewhere
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
      rdata_o <= 8'h00;
    else if (req_i.rd)
    begin
      unique case (req_i.addr)
        ack_mgr_pkg::CTRL_ADDR:
          rdata_o <= {4'h0, mode_buf, lb_nack, gc_en, ack_en};
        ack_mgr_pkg::COUNT_ADDR:
          rdata_o <= {1'b0, byte_count};
        ack_mgr_pkg::STATUS_ADDR:
          rdata_o <= status_code;
        ack_mgr_pkg::IRQ_STAT_ADDR:
          rdata_o <= {{(8-EV_W_L){1'b0}}, irq_stat};
        ack_mgr_pkg::IRQ_EN_ADDR:
          rdata_o <= {{(8-EV_W_L){1'b0}}, irq_en};
        default:
          rdata_o <= 8'h00; // unmapped or write-only
      endcase
    end
    else
      rdata_o <= 8'h00;
  end

  // byte mode master receive follows ack enable
  byte_master_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    slot_i.valid && slot_i.kind == ack_mgr_pkg::SLOT_DATA && slot_i.master && !mode_buf
    |=> ack_valid_o && (ack_o == $past(ack_en)))
    else $error("byte master ack wrong");

  // own address ack follows ack enable in both modes
  own_addr_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    slot_i.valid && slot_i.kind == ack_mgr_pkg::SLOT_OWN_ADDR
    |=> ack_o == $past(ack_en))
    else $error("own address ack wrong");

  // general call address follows its enable
  gc_addr_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    slot_i.valid && slot_i.kind == ack_mgr_pkg::SLOT_GC_ADDR
    |=> ack_o == $past(gc_en) ##1 addressed_o == $past(gc_en, 2))
    else $error("general call ack wrong");

  // buffered master: last byte nack only with last nack set
  buf_last_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    slot_i.valid && slot_i.kind == ack_mgr_pkg::SLOT_DATA && slot_i.master && mode_buf
    && (done + 7'h01) == byte_count |=> ack_o == !$past(lb_nack))
    else $error("buffered last byte wrong");

  // buffered master before the last byte always acks
  buf_mid_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    slot_i.valid && slot_i.kind == ack_mgr_pkg::SLOT_DATA && slot_i.master && mode_buf
    && (done + 7'h01) < byte_count |=> ack_o)
    else $error("buffered mid byte nacked");

  // byte mode refused slave data drops the address
  drop_addr_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    slot_i.valid && slot_i.kind == ack_mgr_pkg::SLOT_DATA && !slot_i.master && !mode_buf
    && !ack_en && !stop_i |=> !ack_o ##1 !addressed_o)
    else $error("refused slave stays addressed");

  // bad count raises the event and status, no start
  bad_count_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    ctrl_wr && req_i.wdata[ack_mgr_pkg::GO_BIT] && req_i.wdata[ack_mgr_pkg::MODE_BIT]
    && count_bad |=> !xfer_start_o && status_code == ack_mgr_pkg::STATUS_BAD_COUNT
    && irq_stat[ack_mgr_pkg::EV_BAD_COUNT])
    else $error("bad count not reported");

  // stop ends any slave session within two cycles
  stop_end_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    stop_i |-> ##2 !addressed_o)
    else $error("stop did not end session");

  // interrupt follows enabled sticky bits
  irq_level_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    |(irq_stat & irq_en) |=> irq_o)
    else $error("interrupt not raised");
endmodule // ack_manager

// file: bus_peer.sv
// far-side bus model: offers acknowledge slots and stop conditions
`timescale 1ns/1ps
module bus_peer (
  input wire logic mclk_i,
  output ack_mgr_pkg::slot_t slot_o,
  output logic stop_o
);
  // quiet bus until the bench asks for something
  initial
  begin
    slot_o = '0;
    stop_o = 1'b0;
  end

  // one acknowledge slot, after an optional idle gap to act slowly
  task automatic offer(input logic [1:0] k, input logic m, input int gap);
    repeat (gap) @(posedge mclk_i);
    @(posedge mclk_i);
    slot_o <= {1'b1, k, m};
    @(posedge mclk_i);
    // a pulse of exactly one edge, as a real engine would give
    slot_o <= '0;
  endtask

  // stop condition ends any open session
  task automatic send_stop();
    @(posedge mclk_i);
    stop_o <= 1'b1;
    @(posedge mclk_i);
    stop_o <= 1'b0;
  endtask
endmodule // bus_peer

// file: tb_top.sv
// self-checking bench for the acknowledge manager
`timescale 1ns/1ps
module tb_top;
  logic mclk_i = 1'b0; // 10 MHz clock
  logic reset_i = 1'b1; // held for two edges
  ack_mgr_pkg::reg_req_t req_i = '0; // register port
  ack_mgr_pkg::slot_t slot_i; // from the peer
  logic stop_i; // from the peer
  logic [7:0] rdata_o;
  logic ack_valid_o, ack_o, addressed_o, xfer_start_o, irq_o;
  int error_cnt = 0;
  int compares = 0;
  int starts = 0; // accepted transfer pulses seen

  // clock
  always #50 mclk_i = ~mclk_i;

  ack_manager ack_manager_inst (.mclk_i(mclk_i), .reset_i(reset_i), .req_i(req_i),
    .slot_i(slot_i), .stop_i(stop_i), .rdata_o(rdata_o), .ack_valid_o(ack_valid_o),
    .ack_o(ack_o), .addressed_o(addressed_o), .xfer_start_o(xfer_start_o), .irq_o(irq_o));
  bus_peer bus_peer_inst (.mclk_i(mclk_i), .slot_o(slot_i), .stop_o(stop_i));

  // count start pulses; sampled before the edge's own updates land
  always @(posedge mclk_i)
    if (xfer_start_o === 1'b1)
      starts++;

  // verdict and end of run
  task automatic finish_test();
    if (error_cnt == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // compare one byte-wide result
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle register write
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    req_i <= {1'b1, 1'b0, a, d};
    @(posedge mclk_i);
    req_i <= '0;
  endtask

  // one-cycle read, data checked in the following cycle only
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    req_i <= {1'b0, 1'b1, a, 8'h00};
    @(posedge mclk_i);
    req_i <= '0;
    #1;
    chk("rdata", exp, rdata_o);
  endtask

  // slot offered by the peer, decision checked one cycle later
  task automatic sl(input logic [1:0] k, input logic m, input logic exp);
    bus_peer_inst.offer(k, m, 0);
    #1;
    chk("ack_valid", 8'h01, {7'h00, ack_valid_o});
    chk("ack", {7'h00, exp}, {7'h00, ack_o});
  endtask

  // session level, settled one edge after the decision
  task automatic adr(input logic exp);
    @(posedge mclk_i);
    #1;
    chk("addressed", {7'h00, exp}, {7'h00, addressed_o});
  endtask

  // level outputs checked where they stand
  task automatic lvl(input string what, input logic exp, input logic got);
    chk(what, {7'h00, exp}, {7'h00, got});
  endtask

  // watchdog: the sequence needs well under 1000 cycles
  initial
  begin
    #500000;
    error_cnt++;
    finish_test();
  end

  // main sequence
  initial
  begin
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    // reset values, read-only and unmapped places
    rd(3'h2, 8'hF8);
    rd(3'h1, 8'h00);
    wr(3'h2, 8'h00);
    rd(3'h2, 8'hF8);
    rd(3'h7, 8'h00);
    wr(3'h0, 8'h0F);
    rd(3'h0, 8'h0F);
    // byte-mode master receiver; new setting used at the next slot
    wr(3'h0, 8'h06);
    sl(2'h2, 1'b1, 1'b0);
    wr(3'h0, 8'h01);
    sl(2'h2, 1'b1, 1'b1);
    adr(1'b0);
    // byte-mode slave, ack disabled then enabled
    wr(3'h0, 8'h00);
    sl(2'h0, 1'b0, 1'b0);
    adr(1'b0);
    sl(2'h2, 1'b0, 1'b0);
    wr(3'h0, 8'h01);
    sl(2'h0, 1'b0, 1'b1);
    repeat (3) sl(2'h2, 1'b0, 1'b1);
    adr(1'b1);
    bus_peer_inst.send_stop();
    adr(1'b0);
    // general call in byte mode
    sl(2'h1, 1'b0, 1'b0);
    sl(2'h2, 1'b0, 1'b0);
    wr(3'h0, 8'h02);
    sl(2'h1, 1'b0, 1'b1);
    sl(2'h2, 1'b0, 1'b0);
    bus_peer_inst.send_stop();
    wr(3'h0, 8'h03);
    sl(2'h1, 1'b0, 1'b1);
    sl(2'h2, 1'b0, 1'b1);
    bus_peer_inst.send_stop();
    // buffered general call, count of three
    wr(3'h1, 8'h03);
    wr(3'h0, 8'h09);
    sl(2'h1, 1'b0, 1'b0);
    wr(3'h0, 8'h0A);
    sl(2'h1, 1'b0, 1'b1);
    repeat (3) sl(2'h2, 1'b0, 1'b1);
    bus_peer_inst.send_stop();
    // buffered master receiver ignores ack enable
    wr(3'h0, 8'h08);
    repeat (3) sl(2'h2, 1'b1, 1'b1);
    bus_peer_inst.send_stop();
    wr(3'h0, 8'h0C);
    repeat (2) sl(2'h2, 1'b1, 1'b1);
    sl(2'h2, 1'b1, 1'b0);
    bus_peer_inst.send_stop();
    // buffered slave receiver
    wr(3'h0, 8'h08);
    sl(2'h0, 1'b0, 1'b0);
    wr(3'h0, 8'h09);
    sl(2'h0, 1'b0, 1'b1);
    repeat (3) sl(2'h2, 1'b0, 1'b1);
    sl(2'h2, 1'b0, 1'b0);
    adr(1'b0);
    wr(3'h0, 8'h0D);
    sl(2'h0, 1'b0, 1'b1);
    repeat (2) sl(2'h2, 1'b0, 1'b1);
    sl(2'h2, 1'b0, 1'b0);
    sl(2'h0, 1'b0, 1'b1);
    sl(2'h2, 1'b0, 1'b1);
    bus_peer_inst.send_stop();
    adr(1'b0);
    // transfer requests, count limits and the interrupt
    wr(3'h5, 8'h07);
    wr(3'h4, 8'h01);
    rd(3'h3, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h18);
    rd(3'h2, 8'hFC);
    rd(3'h3, 8'h01);
    lvl("irq", 1'b1, irq_o);
    wr(3'h4, 8'h00);
    rd(3'h3, 8'h01);
    lvl("irq", 1'b0, irq_o);
    wr(3'h5, 8'h01);
    rd(3'h3, 8'h00);
    wr(3'h4, 8'h01);
    wr(3'h1, 8'h45);
    wr(3'h0, 8'h18);
    rd(3'h2, 8'hFC);
    lvl("irq", 1'b1, irq_o);
    wr(3'h5, 8'h01);
    rd(3'h3, 8'h00);
    lvl("irq", 1'b0, irq_o);
    chk("starts", 8'h00, starts[7:0]);
    wr(3'h1, 8'h44);
    wr(3'h0, 8'h18);
    rd(3'h2, 8'h08);
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h10);
    rd(3'h2, 8'h08);
    chk("starts", 8'h02, starts[7:0]);
    // mid-run reset: status, mask and settings go back to reset values
    @(posedge mclk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    rd(3'h2, 8'hF8);
    rd(3'h4, 8'h00);
    rd(3'h0, 8'h00);
    finish_test();
  end
endmodule // tb_top
